// file: inc/tss_consts.svh
// Purpose: Shared constants of the time-slot switch
// Assumes: One internal cycle per rising master clock edge
// Notes: Definitions only
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
`define TSS_LINKS 4
`define TSS_CM_DEPTH 128
`define TSS_IN_PRESET 9'h000
`define TSS_TB_DIFF 9'h020
`define TSS_OUT_PRESET 9'h020
`define TSS_CM_IDLE 9'h1ff
`define TSS_SEL_BIT 8
`define TSS_OP_CONNECT 4'h1
`define TSS_OP_DISC 4'h2
`define TSS_OP_INSERT 4'h3
`define TSS_OP_SAMPLE 4'h4
`define TSS_OP_CTRL 4'h5
`define TSS_FIFO_DEPTH 8
`define TSS_FIFO_W 9
`define TSS_PH_WR_FIRST 4'h1
`define TSS_PH_WR_LAST 4'h4
`define TSS_PH_BUSY_END 4'h8
`endif

// file: inc/tss_pkg.sv
// Purpose: Types of the time-slot switch
// Assumes: tss_consts.svh on the include path
// Notes: Types only
`include "tss_consts.svh"
package tss_pkg;
   // Executor states, Gray along idle, run, done
   typedef enum logic [1:0] {EX_IDLE = 2'h0, EX_RUN = 2'h1, EX_DONE = 2'h3} tss_ex_t;
   // Pins as seen after each synchroniser stage
   typedef struct packed {
      logic [`TSS_LINKS-1:0] pcm_in;
      logic [7:0] bus;
      logic cs_a_n;
      logic cs_b_n;
      logic cmd_sel;
      logic wr_n;
      logic rd_n;
      logic sync_n;
   } tss_pins_t;
   // Whole state of the switch top
   typedef struct packed {
      tss_pins_t m1;
      tss_pins_t m2;
      tss_pins_t m3;
      logic [8:0] in_cnt;
      logic [8:0] out_cnt;
      logic [3:0][7:0] sh_in;
      logic [3:0][7:0] hold;
      logic [3:0][7:0] nxt_out;
      logic [3:0][7:0] sh_out;
      logic [3:0] pout;
      logic [3:0] poe;
      logic [3:0][4:0] stack;
      logic [1:0] wp;
      logic [3:0] op;
      tss_ex_t ex;
      logic [7:0] or1;
      logic [7:0] or2;
      logic dav;
      logic [7:0] bus_out;
      logic bus_oe;
      logic init;
      logic [6:0] init_idx;
   } tss_state_t;
endpackage

// file: rtl/tss_switch.sv
// Purpose: PCM time-slot switch with processor port
// Assumes: Pins are asynchronous to i_mclk
// Notes: Function
// Function
// RQ1: Two timebases, preset on frame sync
// RQ2: Input base lags, output base leads
// RQ3: Slot start writes each link byte
// RQ4: Entry holds store address or literal
// RQ5: Ninth bit picks literal over stored
// RQ6: Output base scans, leaves spare cycles
// RQ7: First readback shows memory contents
// RQ8: Second readback shows opcode plus status
// RQ9: Four operand stack, separate opcode register
// RQ10: Sample result ready five to fourteen clocks
// RQ11: Data available low two clocks maximum
// RQ12: Processor memory access only in spares
// RQ13: Select line picks operand/opcode, readback
// RQ14: Reset fills connections ones, releases pins
// RQ15: Timebases differ by thirty-two cycles
// RQ16: Links carry sign bit first, MSB
`timescale 1ns/1ps
`include "tss_consts.svh"

module tss_fifo #(
   parameter int W = `TSS_FIFO_W,
   parameter int D = `TSS_FIFO_DEPTH,
   parameter int AW = $clog2(D)
) (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_ready,
   output logic o_valid,
   output logic [W-1:0] o_data,
   input wire logic i_ready
);
   // Pointers and fill level
   typedef struct packed {
      logic [AW:0] cnt;
      logic [AW-1:0] rp;
      logic [AW-1:0] wp;
      logic rdy;
   } tss_fifo_st_t;
   tss_fifo_st_t f, f_nxt;
   logic [W-1:0] mem [D];
   logic push, pop;

   assign o_ready = f.rdy;
   assign o_valid = (f.cnt != '0);
   assign o_data = mem[f.rp];

   // Pointer update; ready registered so full never lets a word in
   always_comb begin
      f_nxt = f;
      push = i_valid && f.rdy;
      pop = o_valid && i_ready;
      if (push) begin
         f_nxt.wp = f.wp + 1'b1;
      end
      if (pop) begin
         f_nxt.rp = f.rp + 1'b1;
      end
      f_nxt.cnt = f.cnt + (AW+1)'(push) - (AW+1)'(pop);
      f_nxt.rdy = (f_nxt.cnt != (AW+1)'(D));
   end

   // State register
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         f <= '0;
         f.rdy <= 1'b1;
      end else begin
         f <= f_nxt;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[f.wp] <= i_data;
      end
   end
endmodule

module tss_switch (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_sync_n,
   input wire logic [`TSS_LINKS-1:0] i_pcm_in,
   output logic [`TSS_LINKS-1:0] o_pcm_out,
   output logic [`TSS_LINKS-1:0] o_pcm_oe,
   input wire logic [7:0] i_bus,
   output logic [7:0] o_bus,
   output logic o_bus_oe,
   input wire logic i_cmd_sel,
   input wire logic i_chip_select_a_n,
   input wire logic i_chip_select_b_n,
   input wire logic i_wr_n,
   input wire logic i_rd_n,
   output logic o_data_available,
   output logic o_cmd_ready
);
   tss_pkg::tss_state_t st, st_nxt; // Whole state
   tss_pkg::tss_pins_t pins; // Raw pins
   logic [8:0] cm_mem [`TSS_CM_DEPTH]; // Connection store
   logic [7:0] sm_mem [`TSS_CM_DEPTH]; // Speech store
   logic cm_we, sm_we, f_push, f_pop, f_valid;
   logic [6:0] cm_addr, sm_waddr, sm_raddr;
   logic [8:0] cm_wd, cm_rd, f_data;
   logic [7:0] sm_wd, sm_rd;
   logic [3:0] iph, oph;
   logic [1:0] k;

   // PCM slots own the store on odd phases of the first half slot
   function automatic logic cm_busy(input logic [3:0] ph);
      return ph[0] && (ph < `TSS_PH_BUSY_END);
   endfunction

   // Chip selected: both selects low
   function automatic logic sel_ok(input tss_pkg::tss_pins_t p);
      return !p.cs_a_n && !p.cs_b_n;
   endfunction

   assign pins = '{pcm_in: i_pcm_in, bus: i_bus, cs_a_n: i_chip_select_a_n,
                   cs_b_n: i_chip_select_b_n, cmd_sel: i_cmd_sel, wr_n: i_wr_n,
                   rd_n: i_rd_n, sync_n: i_sync_n};
   assign cm_rd = cm_mem[cm_addr];
   assign sm_rd = sm_mem[sm_raddr];
   assign o_pcm_out = st.pout;
   assign o_pcm_oe = st.poe;
   assign o_bus = st.bus_out;
   assign o_bus_oe = st.bus_oe;
   assign o_data_available = st.dav;

   // Processor bytes queue here; executor drains only when idle
   tss_fifo #(.W(`TSS_FIFO_W), .D(`TSS_FIFO_DEPTH)) u_fifo (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_valid(f_push),
      .i_data({st.m3.cmd_sel, st.m3.bus}),
      .o_ready(o_cmd_ready),
      .o_valid(f_valid),
      .o_data(f_data),
      .i_ready(f_pop)
   );

   // Next-state logic of the whole switch
   always_comb begin
      st_nxt = st;
      cm_we = 1'b0;
      cm_addr = '0;
      cm_wd = `TSS_CM_IDLE;
      sm_we = 1'b0;
      sm_waddr = '0;
      sm_wd = '0;
      sm_raddr = '0;
      f_pop = 1'b0;
      k = '0;
      // Two-stage synchronisers, third stage for edges
      st_nxt.m1 = pins;
      st_nxt.m2 = st.m1;
      st_nxt.m3 = st.m2;
      // Both timebases count every internal cycle
      st_nxt.in_cnt = st.in_cnt + 9'h001; // RQ1
      st_nxt.out_cnt = st.out_cnt + 9'h001; // RQ1
      if (st.m3.sync_n && !st.m2.sync_n) begin
         st_nxt.in_cnt = `TSS_IN_PRESET; // RQ1 RQ2
         st_nxt.out_cnt = `TSS_OUT_PRESET; // RQ15
      end
      iph = st.in_cnt[3:0];
      oph = st.out_cnt[3:0];
      // Sample in mid-bit, first bit lands in MSB
      if (iph[0]) begin
         for (int i = 0; i < `TSS_LINKS; i++) begin
            st_nxt.sh_in[i] = {st.sh_in[i][6:0], st.m2.pcm_in[i]}; // RQ16
         end
      end
      // Slot start: freeze bytes, then one link per cycle
      if (iph == 4'h0) begin
         st_nxt.hold = st.sh_in;
      end
      if (iph >= `TSS_PH_WR_FIRST && iph <= `TSS_PH_WR_LAST) begin
         k = 2'(iph - `TSS_PH_WR_FIRST);
         sm_we = 1'b1; // RQ3
         sm_waddr = {k, st.in_cnt[8:4] - 5'h01}; // RQ3
         sm_wd = st.hold[k];
      end
      // Output scan: one pin per busy phase
      if (cm_busy(oph)) begin
         k = oph[2:1];
         cm_addr = {k, st.out_cnt[8:4]}; // RQ6
         sm_raddr = cm_rd[6:0]; // RQ4
         st_nxt.nxt_out[k] = cm_rd[`TSS_SEL_BIT] ? cm_rd[7:0] : sm_rd; // RQ5
      end
      // Serialiser: load at slot start, shift each bit time
      if (oph == 4'h0) begin
         st_nxt.sh_out = st.nxt_out;
      end else if (!oph[0]) begin
         for (int i = 0; i < `TSS_LINKS; i++) begin
            st_nxt.sh_out[i] = {st.sh_out[i][6:0], 1'b1}; // RQ16
         end
      end
      for (int i = 0; i < `TSS_LINKS; i++) begin
         st_nxt.pout[i] = st_nxt.sh_out[i][7];
         st_nxt.poe[i] = !st_nxt.sh_out[i][7] && !st.init; // RQ14
      end
      // Write strobe end; both strobes low protects inputs
      f_push = st.m3.sync_n && !st.m3.wr_n && st.m2.wr_n && st.m3.rd_n
               && sel_ok(st.m3) && !st.init; // RQ13
      // Read drive; a clash of strobes floats the bus
      st_nxt.bus_oe = !st.m2.rd_n && st.m2.wr_n && sel_ok(st.m2) && !st.init;
      st_nxt.bus_out = st.m2.cmd_sel ? st.or2 : st.or1; // RQ13
      // Executor
      unique case (st.ex)
         tss_pkg::EX_IDLE: begin
            f_pop = f_valid && !st.init;
            if (f_pop && f_data[8]) begin
               st_nxt.op = f_data[3:0]; // RQ9
               st_nxt.wp = '0;
               st_nxt.ex = tss_pkg::EX_RUN;
            end else if (f_pop) begin
               st_nxt.stack[st.wp] = f_data[4:0]; // RQ9
               st_nxt.wp = st.wp + 2'h1;
            end
         end
         tss_pkg::EX_RUN: begin
            // Waits out PCM phases so no scheduled access is lost
            if (!cm_busy(oph)) begin // RQ12
               if (st.op == `TSS_OP_CONNECT || st.op == `TSS_OP_INSERT) begin
                  cm_addr = {st.stack[2][1:0], st.stack[3]};
               end else begin
                  cm_addr = {st.stack[0][1:0], st.stack[1]};
               end
               sm_raddr = cm_rd[6:0];
               st_nxt.or2 = {st.stack[0][2:0], cm_rd[`TSS_SEL_BIT], st.op}; // RQ8
               st_nxt.or1 = cm_rd[7:0]; // RQ7
               st_nxt.ex = tss_pkg::EX_DONE;
               unique case (st.op)
                  `TSS_OP_CONNECT, `TSS_OP_INSERT: begin
                     cm_we = 1'b1;
                     cm_wd = {st.op == `TSS_OP_INSERT, st.stack[0][2:0], st.stack[1]};
                     st_nxt.or1 = cm_wd[7:0]; // RQ7
                     st_nxt.or2 = {st.stack[2][2:0], cm_wd[`TSS_SEL_BIT], st.op};
                  end
                  `TSS_OP_DISC: begin
                     cm_we = 1'b1;
                     st_nxt.or1 = cm_wd[7:0];
                     st_nxt.or2 = {st.stack[0][2:0], cm_wd[`TSS_SEL_BIT], st.op};
                  end
                  `TSS_OP_SAMPLE: begin
                     st_nxt.or1 = cm_rd[`TSS_SEL_BIT] ? cm_rd[7:0] : sm_rd; // RQ7
                     st_nxt.dav = 1'b0; // RQ11
                  end
                  `TSS_OP_CTRL: begin
                     st_nxt.dav = 1'b0; // RQ11
                  end
                  default: begin
                     cm_we = 1'b0;
                  end
               endcase
            end
         end
         tss_pkg::EX_DONE: begin
            st_nxt.dav = 1'b1; // RQ10 RQ11
            st_nxt.ex = tss_pkg::EX_IDLE;
         end
         default: begin
            st_nxt.ex = tss_pkg::EX_IDLE;
         end
      endcase
      // Start-up fill beats every other store user
      if (st.init) begin
         cm_we = 1'b1;
         cm_addr = st.init_idx;
         cm_wd = `TSS_CM_IDLE; // RQ14
         st_nxt.init_idx = st.init_idx + 7'h01;
         st_nxt.init = (st.init_idx != 7'h7f);
      end
   end

   // State register; pins idle high through reset
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '0;
         st.m1 <= '1;
         st.m2 <= '1;
         st.m3 <= '1;
         st.in_cnt <= `TSS_IN_PRESET;
         st.out_cnt <= `TSS_OUT_PRESET; // RQ15
         st.nxt_out <= '1;
         st.sh_out <= '1;
         st.pout <= '1;
         st.init <= 1'b1; // RQ14
         st.dav <= 1'b1;
      end else begin
         st <= st_nxt;
      end
   end

   // Store write ports
   always_ff @(posedge i_mclk) begin
      if (cm_we) begin
         cm_mem[cm_addr] <= cm_wd;
      end
      if (sm_we) begin
         sm_mem[sm_waddr] <= sm_wd;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);

   property p_preset;
      (st.m3.sync_n && !st.m2.sync_n) |=> (st.in_cnt == `TSS_IN_PRESET)
         && (st.out_cnt == `TSS_OUT_PRESET);
   endproperty
   a_preset: assert property (p_preset) else $error("timebase preset wrong"); // RQ1

   property p_diff;
      st.out_cnt == st.in_cnt + `TSS_TB_DIFF;
   endproperty
   a_diff: assert property (p_diff) else $error("timebase gap wrong"); // RQ15

   // Frame sync may preset mid-slot, so tie writes to the phase itself
   property p_slotwr;
      sm_we == (st.in_cnt[3:0] >= `TSS_PH_WR_FIRST && st.in_cnt[3:0] <= `TSS_PH_WR_LAST);
   endproperty
   a_slotwr: assert property (p_slotwr) else $error("slot write missed"); // RQ3

   property p_spare;
      (st.ex == tss_pkg::EX_RUN && cm_busy(oph) && !st.init) |=> st.ex == tss_pkg::EX_RUN;
   endproperty
   a_spare: assert property (p_spare) else $error("access in busy phase"); // RQ12

   property p_lit;
      (cm_busy(oph) && !st.init && cm_rd[`TSS_SEL_BIT]) |=>
         st.nxt_out[$past(oph[2:1])] == $past(cm_rd[7:0]);
   endproperty
   a_lit: assert property (p_lit) else $error("literal not taken"); // RQ5

   property p_rst;
      st.init |-> !o_bus_oe && (o_pcm_oe == 4'h0);
   endproperty
   a_rst: assert property (p_rst) else $error("pins driven in init"); // RQ14

   property p_dav;
      (f_push && st.m3.cmd_sel && !f_valid && st.ex == tss_pkg::EX_IDLE
         && (st.m3.bus[3:0] == `TSS_OP_SAMPLE)) |-> ##[3:8] $rose(o_data_available);
   endproperty
   a_dav: assert property (p_dav) else $error("data available late"); // RQ10

   property p_low;
      $fell(o_data_available) |-> ##[1:2] o_data_available;
   endproperty
   a_low: assert property (p_low) else $error("data available low too long"); // RQ11

   property p_opc;
      (f_pop && f_data[8]) |=> st.wp == 2'h0 && st.op == $past(f_data[3:0]);
   endproperty
   a_opc: assert property (p_opc) else $error("opcode not captured"); // RQ9

   property p_clash;
      (!st.m2.rd_n && !st.m2.wr_n) |=> !o_bus_oe;
   endproperty
   a_clash: assert property (p_clash) else $error("bus driven in clash"); // RQ13
endmodule

// file: tb/tss_cpu_model.sv
// Purpose: Processor model on the parallel port of the switch
// Assumes: Strobes move just after rising mclk edges
// Notes: A released bus shows the inverted last byte, never stale data
`timescale 1ns/1ps
module tss_cpu_model (
   input wire logic i_mclk,
   output logic [7:0] o_bus,
   output logic o_cmd_sel,
   output logic o_cs_a_n,
   output logic o_wr_n,
   output logic o_rd_n
);
   // Idle: strobes high, chip not selected
   initial begin
      o_bus = 8'h00;
      o_cmd_sel = 1'b0;
      o_cs_a_n = 1'b1;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
   end
   // One strobe, 5 clocks low; select and byte held a clock past its end
   task automatic access(input logic wr, input logic sel, input logic [7:0] d, input logic cs_n);
      @(posedge i_mclk);
      o_cmd_sel <= sel;
      o_bus <= d;
      o_cs_a_n <= cs_n;
      o_wr_n <= !wr;
      o_rd_n <= wr;
      repeat (5) @(posedge i_mclk);
      o_wr_n <= 1'b1;
      o_rd_n <= 1'b1;
      @(posedge i_mclk);
      o_cs_a_n <= 1'b1;
      o_bus <= ~d; // Released: inverse, so no stale match
      repeat (4) @(posedge i_mclk);
   endtask
endmodule

// file: tb/tb_tss_switch.sv
// Purpose: Self-checking bench of the time-slot switch
// Assumes: Frame of 512 clocks; literal bytes keep their MSB low
// Notes: Readbacks are queued by the driver and checked by a watcher
`timescale 1ns/1ps
`include "tss_consts.svh"
module tb_tss_switch;
   logic i_mclk, i_rstn, i_sync_n;
   logic [`TSS_LINKS-1:0] i_pcm_in, o_pcm_out, o_pcm_oe, pcm_wire;
   logic [7:0] i_bus, o_bus, cpu_bus, lit;
   logic o_bus_oe, cmd_sel, cs_a_n, wr_n, rd_n, o_data_available, o_cmd_ready;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 32'h9430;
   int oe_cnt = 0; // Cycles the port has driven
   int since_wr = 0; // Clocks since write strobe end
   int low_w = 0; // Current flag drop width
   int dr_at, dr_w, k1, k2; // Last flag pulse, byte positions
   logic dr_seen = 1'b0;
   logic wr_d = 1'b1;
   logic [15:0] exp_q[$]; // Expected readbacks, oldest first
   logic [511:0] frame; // One frame of the line under test
   logic [1:0] p, q; // Input and output links
   logic [4:0] x, y; // Input and output slots
   // Open-drain lines pulled up; bus resolved from both drivers
   assign pcm_wire = ~o_pcm_oe;
   assign i_bus = o_bus_oe ? o_bus : cpu_bus;
   tss_cpu_model cpu (.i_mclk(i_mclk), .o_bus(cpu_bus), .o_cmd_sel(cmd_sel),
      .o_cs_a_n(cs_a_n), .o_wr_n(wr_n), .o_rd_n(rd_n));
   tss_switch dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_sync_n(i_sync_n),
      .i_pcm_in(i_pcm_in), .o_pcm_out(o_pcm_out), .o_pcm_oe(o_pcm_oe), .i_bus(i_bus),
      .o_bus(o_bus), .o_bus_oe(o_bus_oe), .i_cmd_sel(cmd_sel), .i_chip_select_a_n(cs_a_n),
      .i_chip_select_b_n(1'b0), .i_wr_n(wr_n), .i_rd_n(rd_n),
      .o_data_available(o_data_available), .o_cmd_ready(o_cmd_ready));
   // Free-running master clock
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Noise on all links except p, which carries zeros for the connect case
   always @(posedge i_mclk) begin
      i_pcm_in <= 4'($random(seed)) & ~(4'h1 << p);
   end
   // Flag timing against the last write strobe end; hang guard
   always @(posedge i_mclk) begin
      wr_d <= wr_n;
      cyc <= cyc + 1;
      since_wr <= (wr_n && !wr_d) ? 1 : since_wr + 1;
      low_w <= o_data_available ? 0 : low_w + 1;
      if (o_data_available === 1'b1 && low_w > 0) begin
         dr_seen <= 1'b1;
         dr_at <= since_wr;
         dr_w <= low_w;
      end
      if (cyc == 20000) begin
         check(16'h0, 16'h1, "timeout");
         conclude();
      end
   end
   // Readback watcher: second driven cycle is compared to oldest note
   always @(negedge i_mclk) begin
      oe_cnt = (o_bus_oe === 1'b1) ? oe_cnt + 1 : 0;
      if (oe_cnt == 2) begin
         if (exp_q.size() == 0) begin
            exp_q.push_back(16'hdead); // Unasked drive shows as a mismatch
         end
         check(16'(o_bus), exp_q.pop_front(), "readback");
      end
   end
   // Operands then opcode; flag watch restarted just before the opcode
   task automatic op(input logic [3:0] code, input logic [4:0] e0, e1, e2, e3, input int n,
         input logic cs_n);
      logic [4:0] e[4];
      e = '{e0, e1, e2, e3};
      for (int i = 0; i < n; i++) begin
         cpu.access(1'b1, 1'b0, {3'h0, e[i]}, 1'b0);
      end
      dr_seen = 1'b0;
      cpu.access(1'b1, 1'b1, {4'h0, code}, cs_n);
      repeat (30) @(posedge i_mclk);
   endtask
   // Both readbacks, expectations noted first
   task automatic rds(input logic [7:0] r1, input logic [7:0] r2);
      exp_q.push_back(16'(r1));
      cpu.access(1'b0, 1'b0, 8'h00, 1'b0);
      exp_q.push_back(16'(r2));
      cpu.access(1'b0, 1'b1, 8'h00, 1'b0);
   endtask
   task automatic flag_chk();
      check(16'(dr_seen), 16'h1, "flag pulse");
      check(16'(dr_at >= 5 && dr_at <= 14), 16'h1, "flag delay");
      check(16'(dr_w >= 1 && dr_w <= 2), 16'h1, "flag low width");
   endtask
   // Sync at a random phase, then find byte b on link q, sign bit first
   task automatic sync_grab(input logic [7:0] b, output int k);
      int zeros;
      int ok;
      int odd;
      zeros = 0;
      odd = 0;
      k = -1;
      repeat (40 + ($random(seed) & 255)) @(posedge i_mclk);
      i_sync_n <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_sync_n <= 1'b1;
      repeat (20) @(posedge i_mclk);
      for (int i = 0; i < 512; i++) begin
         @(negedge i_mclk);
         frame[i] = pcm_wire[q];
         zeros += (frame[i] !== 1'b1);
         odd += (o_pcm_out[q] !== pcm_wire[q]);
      end
      check(16'(odd), 16'h0, "line value against drive");
      for (int c = 0; c < 512; c++) begin
         ok = 1;
         for (int j = 0; j < 16; j++) begin
            if (frame[(c + j) % 512] !== b[7 - j / 2]) ok = 0;
         end
         if (ok == 1 && k < 0) k = c;
      end
      check(16'(zeros), 16'(16 - 2 * $countones(b)), "line low count");
      check(16'(k >= 0), 16'h1, "byte on line");
   endtask
   // Main sequence
   initial begin
      i_rstn = 1'b0;
      i_sync_n = 1'b1;
      i_pcm_in = '0;
      p = 2'($random(seed));
      q = 2'($random(seed));
      x = 5'($random(seed));
      y = 5'($random(seed));
      lit = {1'b0, 7'($random(seed))};
      repeat (3) @(posedge i_mclk);
      check(16'(o_pcm_oe), 16'h0, "reset lines");
      check(16'({o_bus_oe, o_data_available, o_cmd_ready}), 16'h3, "reset port");
      i_rstn <= 1'b1;
      repeat (140) @(posedge i_mclk);
      sync_grab(8'hff, k1);
      op(`TSS_OP_INSERT, {2'h0, lit[7:5]}, lit[4:0], {3'h0, q}, y, 4, 1'b0);
      check(16'(dr_seen), 16'h0, "flag on insert");
      rds(lit, {1'b0, q, 1'b1, `TSS_OP_INSERT});
      sync_grab(lit, k1);
      sync_grab(lit, k2);
      check(16'(k1), 16'(k2), "slot position after sync");
      op(`TSS_OP_SAMPLE, {3'h0, q}, y, 5'h0, 5'h0, 2, 1'b0);
      flag_chk();
      rds(lit, {1'b0, q, 1'b1, `TSS_OP_SAMPLE});
      op(`TSS_OP_CTRL, {3'h0, q}, y, 5'h0, 5'h0, 2, 1'b0);
      flag_chk();
      rds(lit, {1'b0, q, 1'b1, `TSS_OP_CTRL});
      op(`TSS_OP_SAMPLE, 5'h0, 5'h0, 5'h0, 5'h0, 0, 1'b1);
      check(16'(dr_seen), 16'h0, "deselected opcode");
      op(`TSS_OP_CONNECT, {3'h0, p}, x, {3'h0, q}, y, 4, 1'b0);
      rds({1'b0, p, x}, {1'b0, q, 1'b0, `TSS_OP_CONNECT});
      sync_grab(8'h00, k1);
      op(`TSS_OP_SAMPLE, {3'h0, q}, y, 5'h0, 5'h0, 2, 1'b0);
      flag_chk();
      rds(8'h00, {1'b0, q, 1'b0, `TSS_OP_SAMPLE});
      op(`TSS_OP_DISC, {3'h0, q}, y, 5'h0, 5'h0, 2, 1'b0);
      rds(8'hff, {1'b0, q, 1'b1, `TSS_OP_DISC});
      sync_grab(8'hff, k2);
      check(16'(exp_q.size()), 16'h0, "readbacks left");
      conclude();
   end
endmodule
